// ===== common/eip_map.svh
// register offsets, field positions and reset values of the interrupt unit
`ifndef EIP_MAP_SVH
`define EIP_MAP_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define EIP_STATUS_CONTROL_OFS 12'h000
`define EIP_CONFIG_TWO_OFS     12'h004
`define EIP_IRQ_STATUS_OFS     12'h008
`define EIP_IRQ_MASK_OFS       12'h00C
`define EIP_VECTOR_OFS         12'h010
`define EIP_ADDR_W             12

// ****************************************************************
// field positions
// ****************************************************************
`define EIP_MODE_BIT    0
`define EIP_MASK_BIT    1
`define EIP_ACK_BIT     2
`define EIP_PEND_BIT    3
`define EIP_PIN_BIT     4
`define EIP_ENABLE_BIT  0
`define EIP_EV_LATCH    0
`define EIP_EV_WAKE     1
`define EIP_EV_W        2

// ****************************************************************
// reset values and vector address
// ****************************************************************
`define EIP_VECTOR_RST  16'hFFFA
`define EIP_ZERO32      32'h0000_0000

`endif

// ===== common/eip_pkg.sv
// types shared by the interrupt unit
package eip_pkg;
    typedef enum logic [1:0] {
        EIP_RUN,
        EIP_WAIT,
        EIP_STOP
    } eip_power_e;
endpackage

// ===== dv/eip_pin_driver.sv
// model of the switch driving the interrupt pin
`timescale 1ns/1ps
`default_nettype none
module eip_pin_driver (
    // clock
    input  wire logic pclk,
    // pin, pulled up while released
    output logic      pin_n
);
    initial pin_n = 1'b1;
    task automatic drop();
        @(posedge pclk);
        pin_n <= 1'b0;
    endtask
    task automatic lift();
        @(posedge pclk);
        pin_n <= 1'b1;
    endtask
endmodule // eip_pin_driver
`default_nettype wire

// ===== dv/eip_unit_bench.sv
// self-checking testbench of the external interrupt pin unit
`timescale 1ns/1ps
`default_nettype none
`include "eip_map.svh"
module eip_unit_bench;
    import eip_pkg::*;
    localparam int LIMIT = 3000;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, pin_n, shared_pin_in, cpu_irq_req;
    logic        vector_fetch = 1'b0;
    logic        wait_mode = 1'b0;
    logic        stop_mode = 1'b0;
    logic [15:0] vector_addr;
    logic        branch_if_pin_high, branch_if_pin_low, wake_up, irq;
    logic [3:0]  strb = 4'hf;
    logic        pk = 1'b0;
    logic [31:0] seed = 32'h87b3;
    logic [31:0] exp_q[$];
    int          err_count = 0;
    int          tests_run = 0;
    int          cycles = 0;
    always #10 pclk = ~pclk;
    eip_pin_driver drv (.pclk(pclk), .pin_n(pin_n));
    eip_unit uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_pin_n(pin_n), .shared_pin_in(shared_pin_in),
        .vector_fetch(vector_fetch), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .cpu_irq_req(cpu_irq_req),
        .vector_addr(vector_addr), .branch_if_pin_high(branch_if_pin_high),
        .branch_if_pin_low(branch_if_pin_low), .wake_up(wake_up), .irq(irq)
    );
    // ****************************************************************
    // scoreboard and bus tasks
    // ****************************************************************
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        tests_run++;
        if (got !== want) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic judge(input logic [31:0] got);
        check(got, exp_q.pop_front());
    endtask
    function automatic logic unmapped(input logic [11:0] a);
        unmapped = a != `EIP_STATUS_CONTROL_OFS && a != `EIP_CONFIG_TWO_OFS
                 && a != `EIP_IRQ_STATUS_OFS && a != `EIP_IRQ_MASK_OFS
                 && a != `EIP_VECTOR_OFS;
    endfunction
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // read data stands in the access cycle and is taken at its edge
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready) judge(prdata);
        if (psel && penable && pready) check({31'h0, pslverr},
            {31'h0, unmapped(paddr)});
        if (pk) judge({vector_addr, 10'h000, irq, wake_up, cpu_irq_req,
            branch_if_pin_low, branch_if_pin_high, shared_pin_in});
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_count++;
            conclude();
        end
    end
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        seed = lfsr(seed);
        bus(1'b1, a, d | (seed & 32'hFFFF_FFE0)); // unused bits random
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    task automatic peek(input logic [5:0] v);
        @(posedge pclk);
        exp_q.push_back({`EIP_VECTOR_RST, 10'h000, v});
        pk <= 1'b1;
        @(posedge pclk);
        pk <= 1'b0;
    endtask
    task automatic jitter();
        seed = lfsr(seed);
        repeat (3 + seed[1:0]) @(posedge pclk);
    endtask
    task automatic fetch();
        @(posedge pclk);
        vector_fetch <= 1'b1;
        @(posedge pclk);
        vector_fetch <= 1'b0;
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(`EIP_STATUS_CONTROL_OFS, 32'h0000_0010);
        rd(`EIP_CONFIG_TWO_OFS, 32'h0000_0000);
        rd(`EIP_VECTOR_OFS, 32'h0000_FFFA);
        rd(12'h020, 32'h0000_0000);
        drv.drop();
        jitter();
        peek(6'h04);
        drv.lift();
        jitter();
        rd(`EIP_STATUS_CONTROL_OFS, 32'h0000_0010);
        wr(`EIP_CONFIG_TWO_OFS, 32'h0000_0001);
        wr(`EIP_IRQ_MASK_OFS, 32'h0000_0003);
        peek(6'h03);
        drv.drop();
        jitter();
        peek(6'h2D);
        rd(`EIP_STATUS_CONTROL_OFS, 32'h0000_0008);
        wr(`EIP_STATUS_CONTROL_OFS, 32'h0000_0004);
        rd(`EIP_STATUS_CONTROL_OFS, 32'h0000_0000);
        drv.lift();
        drv.drop();
        jitter();
        rd(`EIP_STATUS_CONTROL_OFS, 32'h0000_0008);
        wr(`EIP_STATUS_CONTROL_OFS, 32'h0000_0002);
        peek(6'h25);
        rd(`EIP_STATUS_CONTROL_OFS, 32'h0000_000A);
        wr(`EIP_IRQ_STATUS_OFS, 32'h0000_0003);
        peek(6'h05);
        wr(`EIP_STATUS_CONTROL_OFS, 32'h0000_0000);
        peek(6'h0D);
        fetch();
        rd(`EIP_STATUS_CONTROL_OFS, 32'h0000_0000);
        drv.lift();
        wr(`EIP_STATUS_CONTROL_OFS, 32'h0000_0001);
        drv.drop();
        jitter();
        wr(`EIP_STATUS_CONTROL_OFS, 32'h0000_0005);
        rd(`EIP_STATUS_CONTROL_OFS, 32'h0000_0009);
        drv.lift();
        jitter();
        rd(`EIP_STATUS_CONTROL_OFS, 32'h0000_0019);
        fetch();
        rd(`EIP_STATUS_CONTROL_OFS, 32'h0000_0011);
        wait_mode <= 1'b1;
        drv.drop();
        jitter();
        peek(6'h3D);
        wait_mode <= 1'b0;
        stop_mode <= 1'b1;
        peek(6'h3D);
        // service routine masks the level request
        wr(`EIP_STATUS_CONTROL_OFS, 32'h0000_0003);
        peek(6'h25);
        stop_mode <= 1'b0;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        jitter();
        rd(`EIP_STATUS_CONTROL_OFS, 32'h0000_0000);
        strb <= 4'h0;
        wr(`EIP_CONFIG_TWO_OFS, 32'h0000_0001);
        strb <= 4'hf;
        rd(`EIP_CONFIG_TWO_OFS, 32'h0000_0000);
        wr(`EIP_CONFIG_TWO_OFS, 32'h0000_0001);
        drv.lift();
        drv.drop();
        jitter();
        wr(`EIP_STATUS_CONTROL_OFS, 32'h0000_0004);
        rd(`EIP_STATUS_CONTROL_OFS, 32'h0000_0000);
        conclude();
    end
endmodule // eip_unit_bench
`default_nettype wire

// ===== rtl/eip_edge_detect.sv
// falling edge detector for the interrupt pin
`timescale 1ns/1ps
`default_nettype none
module eip_edge_detect (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // pin sample
    input  wire logic level_n,
    input  wire logic enable,
    // edge pulse
    output logic      fall
);
    logic last_level;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_level <= 1'b1;
        end else begin
            last_level <= level_n | ~enable;
        end
    end

    // pin counts as high while the function is disabled
    assign fall = enable & last_level & ~level_n;
endmodule // eip_edge_detect
`default_nettype wire

// ===== rtl/eip_unit.sv
// external interrupt pin unit with apb register access
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "eip_map.svh"

// How it works
// RULE1 - enable bit selects interrupt or shared function
// RULE2 - falling pin edge sets sticky latch
// RULE3 - vector fetch clears the latch
// RULE4 - writing ack one clears the latch
// RULE5 - reset clears latch and mode bit
// RULE6 - edge only after reset, level optional
// RULE7 - mask bit blocks request to priority logic
// RULE8 - level mode holds request while pin low
// RULE9 - pin release and acknowledge any order; level mode ack while pin low is lost, latch stays set after release
// RULE10 - edges after acknowledge set latch again
// RULE11 - edge mode acknowledge clears immediately
// RULE12 - pending flag ignores the mask
// RULE13 - taken request loads vector address
// RULE14 - pin level readable for branch tests
// RULE15 - active in wait, request wakes core
// RULE16 - active in stop, request wakes core
// RULE17 - service routine should mask level requests
// RULE18 - acknowledge bit always reads zero
// RULE19 - request is latch, level, mask combined
module eip_unit
    import eip_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // interrupt pin and shared function
    input  wire logic        irq_pin_n,
    output logic             shared_pin_in,
    // cpu side
    input  wire logic        vector_fetch,
    input  wire logic        wait_mode,
    input  wire logic        stop_mode,
    output logic             cpu_irq_req,
    output logic [15:0]      vector_addr,
    output logic             branch_if_pin_high,
    output logic             branch_if_pin_low,
    output logic             wake_up,
    // bus interrupt
    output logic             irq
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic                 ext_int_function_enable;
        logic                 mode_level;
        logic                 ext_int_mask_bit;
        logic                 latch;
        logic                 pin_level;
        logic [`EIP_EV_W-1:0] ev_status;
        logic [`EIP_EV_W-1:0] ev_mask;
        eip_power_e           power;
        logic [31:0]          rdata;
    } eip_state_s;

    eip_state_s state;
    eip_state_s next_state;
    logic       fall;
    logic       acc;
    logic       wr;
    logic       rd;
    logic       sw_ack;
    logic       hw_ack;
    logic       req_level;
    logic       mapped;

    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction

    eip_edge_detect u_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .level_n (irq_pin_n),
        .enable  (state.ext_int_function_enable),
        .fall    (fall)
    );

    // ****************************************************************
    // request logic
    // ****************************************************************
    assign acc    = psel & penable;
    assign wr     = acc & pwrite & pstrb[0];
    // read data is captured in setup so it stands through the access
    assign rd     = psel & ~penable & ~pwrite;
    assign mapped = hit(paddr, `EIP_STATUS_CONTROL_OFS)
                  | hit(paddr, `EIP_CONFIG_TWO_OFS)
                  | hit(paddr, `EIP_IRQ_STATUS_OFS)
                  | hit(paddr, `EIP_IRQ_MASK_OFS)
                  | hit(paddr, `EIP_VECTOR_OFS);
    assign sw_ack = wr & hit(paddr, `EIP_STATUS_CONTROL_OFS)
                  & pwdata[`EIP_ACK_BIT]; // RULE4
    assign hw_ack = vector_fetch & state.latch; // RULE3
    // level mode keeps the request while the pin is low
    assign req_level = state.mode_level & state.ext_int_function_enable
                     & ~irq_pin_n; // RULE8

    always_comb begin
        next_state = state;
        next_state.pin_level = irq_pin_n;
        // set wins over any acknowledge in the same cycle
        if (sw_ack || hw_ack) begin
            next_state.latch = 1'b0; // RULE11 RULE9
        end
        if (fall || req_level) begin
            next_state.latch = 1'b1; // RULE2 RULE10 RULE6
        end
        if (wr && hit(paddr, `EIP_STATUS_CONTROL_OFS)) begin
            next_state.mode_level = pwdata[`EIP_MODE_BIT]; // RULE6
            next_state.ext_int_mask_bit = pwdata[`EIP_MASK_BIT];
        end
        if (wr && hit(paddr, `EIP_CONFIG_TWO_OFS)) begin
            next_state.ext_int_function_enable =
                pwdata[`EIP_ENABLE_BIT]; // RULE1
        end
        if (wr && hit(paddr, `EIP_IRQ_MASK_OFS)) begin
            next_state.ev_mask = pwdata[`EIP_EV_W-1:0];
        end
        if (wr && hit(paddr, `EIP_IRQ_STATUS_OFS)) begin
            next_state.ev_status = state.ev_status
                                 & ~pwdata[`EIP_EV_W-1:0];
        end
        if (fall || req_level) begin
            next_state.ev_status[`EIP_EV_LATCH] = 1'b1;
        end
        if (wake_up) begin
            next_state.ev_status[`EIP_EV_WAKE] = 1'b1;
        end
        case (state.power)
            EIP_RUN: begin
                if (stop_mode) begin
                    next_state.power = EIP_STOP;
                end else if (wait_mode) begin
                    next_state.power = EIP_WAIT;
                end
            end
            EIP_WAIT,
            EIP_STOP: begin
                if (cpu_irq_req || (!wait_mode && !stop_mode)) begin
                    next_state.power = EIP_RUN; // RULE15 RULE16
                end
            end
            default: begin
                next_state.power = EIP_RUN;
            end
        endcase
        next_state.rdata = `EIP_ZERO32;
        if (rd) begin
            if (hit(paddr, `EIP_STATUS_CONTROL_OFS)) begin
                // acknowledge bit reads as zero
                next_state.rdata[`EIP_MODE_BIT] = state.mode_level;
                next_state.rdata[`EIP_MASK_BIT] = state.ext_int_mask_bit;
                next_state.rdata[`EIP_ACK_BIT]  = 1'b0; // RULE18
                next_state.rdata[`EIP_PEND_BIT] = state.latch; // RULE12
                next_state.rdata[`EIP_PIN_BIT]  = state.pin_level;
            end else if (hit(paddr, `EIP_CONFIG_TWO_OFS)) begin
                next_state.rdata[`EIP_ENABLE_BIT] =
                    state.ext_int_function_enable;
            end else if (hit(paddr, `EIP_IRQ_STATUS_OFS)) begin
                next_state.rdata[`EIP_EV_W-1:0] = state.ev_status;
            end else if (hit(paddr, `EIP_IRQ_MASK_OFS)) begin
                next_state.rdata[`EIP_EV_W-1:0] = state.ev_mask;
            end else if (hit(paddr, `EIP_VECTOR_OFS)) begin
                next_state.rdata[15:0] = `EIP_VECTOR_RST;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state.ext_int_function_enable <= 1'b0;
            state.mode_level              <= 1'b0; // RULE5
            state.ext_int_mask_bit        <= 1'b0;
            state.latch                   <= 1'b0; // RULE5
            state.pin_level               <= 1'b1;
            state.ev_status               <= '0;
            state.ev_mask                 <= '0;
            state.power                   <= EIP_RUN;
            state.rdata                   <= `EIP_ZERO32;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // pass the pin to its shared function when disabled
    assign shared_pin_in = state.ext_int_function_enable
                         ? 1'b1 : irq_pin_n; // RULE1
    assign cpu_irq_req = (state.latch | req_level)
                       & ~state.ext_int_mask_bit; // RULE7 RULE19
    assign vector_addr = `EIP_VECTOR_RST; // RULE13
    assign branch_if_pin_high = state.pin_level; // RULE14
    assign branch_if_pin_low  = ~state.pin_level; // RULE14
    // a core still marked asleep counts as sleeping for one more cycle
    assign wake_up = cpu_irq_req
                   & (wait_mode | stop_mode
                      | (state.power != EIP_RUN)); // RULE15 RULE16
    assign irq     = |(state.ev_status & state.ev_mask);
    assign prdata  = state.rdata;
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence ack_seq;
        sw_ack && !fall && !req_level;
    endsequence

    edge_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
        ack_seq and !state.mode_level |=> !state.latch) // RULE11
        else $error("edge mode ack did not clear latch");
    fall_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
        fall |=> state.latch) // RULE2
        else $error("falling edge not latched");
    latch_holds_a: assert property (@(posedge pclk) disable iff (!presetn)
        state.latch && !sw_ack && !hw_ack |=> state.latch) // RULE2
        else $error("latch dropped without ack");
    mask_blocks_a: assert property (@(posedge pclk) disable iff (!presetn)
        state.ext_int_mask_bit |-> !cpu_irq_req) // RULE7
        else $error("masked request forwarded");
    level_holds_a: assert property (@(posedge pclk) disable iff (!presetn)
        req_level && !state.ext_int_mask_bit |-> cpu_irq_req) // RULE8
        else $error("level request dropped while pin low");
    ack_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd && hit(paddr, `EIP_STATUS_CONTROL_OFS)
        |=> !prdata[`EIP_ACK_BIT]) // RULE18
        else $error("ack bit read nonzero");
    pend_reads_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd && hit(paddr, `EIP_STATUS_CONTROL_OFS)
        |=> prdata[`EIP_PEND_BIT] == $past(state.latch)) // RULE12
        else $error("pending flag wrong");
    wake_core_a: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_irq_req && stop_mode |-> wake_up ##1
        state.ev_status[`EIP_EV_WAKE]) // RULE16
        else $error("stop mode wake missing");
    pin_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> branch_if_pin_high == $past(irq_pin_n)) // RULE14
        else $error("pin level not readable");

    // ****************************************************************
    // further checks
    // ****************************************************************
    sequence fetch_seq;
        hw_ack && !fall && !req_level;
    endsequence
    sequence early_ack_seq;
        sw_ack && req_level;
    endsequence
    sequence stop_wake_seq;
        state.power == EIP_STOP && cpu_irq_req;
    endsequence
    sequence wait_wake_seq;
        state.power == EIP_WAIT && cpu_irq_req;
    endsequence

    fetch_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        fetch_seq |=> !state.latch) // RULE3
        else $error("vector fetch did not clear latch");
    high_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sw_ack || hw_ack) && irq_pin_n |=> !state.latch) // RULE9 RULE11
        else $error("ack with pin high did not clear latch");
    early_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
        early_ack_seq |=> state.latch) // RULE9
        else $error("ack cleared a level request while pin low");
    level_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
        req_level |=> state.latch) // RULE8
        else $error("low level did not keep latch set");
    off_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
        !state.ext_int_function_enable |-> !fall && !req_level) // RULE1
        else $error("disabled pin raised a request");
    shared_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
        !state.ext_int_function_enable
        |-> shared_pin_in == irq_pin_n) // RULE1
        else $error("shared function lost the pin");
    shared_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        state.ext_int_function_enable |-> shared_pin_in) // RULE1
        else $error("shared function sees the enabled pin");
    edge_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        !state.mode_level |-> !req_level) // RULE6
        else $error("level request in edge mode");
    vector_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_irq_req |-> vector_addr == `EIP_VECTOR_RST) // RULE13
        else $error("wrong vector address");
    wait_wakes_a: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_irq_req && wait_mode |-> wake_up) // RULE15
        else $error("wait mode wake missing");
    open_req_a: assert property (@(posedge pclk) disable iff (!presetn)
        state.latch && !state.ext_int_mask_bit |-> cpu_irq_req) // RULE7 RULE19
        else $error("unmasked latch not forwarded");
    req_source_a: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_irq_req |-> state.latch || req_level) // RULE19
        else $error("request without a source");
    branch_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
        branch_if_pin_low != branch_if_pin_high) // RULE14
        else $error("pin level tests disagree");
    wake_event_a: assert property (@(posedge pclk) disable iff (!presetn)
        wake_up |=> state.ev_status[`EIP_EV_WAKE]) // RULE15
        else $error("wake event not recorded");
    latch_event_a: assert property (@(posedge pclk) disable iff (!presetn)
        fall || req_level |=> state.ev_status[`EIP_EV_LATCH]) // RULE2
        else $error("latch event not recorded");
    bad_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc && !mapped |-> pslverr)
        else $error("unmapped access without error");
    bad_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd && !mapped |=> prdata == `EIP_ZERO32)
        else $error("unmapped read returned data");
    enable_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd && hit(paddr, `EIP_CONFIG_TWO_OFS) |=> prdata[`EIP_ENABLE_BIT]
        == $past(state.ext_int_function_enable)) // RULE1
        else $error("enable bit read wrong");
    mode_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd && hit(paddr, `EIP_STATUS_CONTROL_OFS)
        |=> prdata[`EIP_MODE_BIT] == $past(state.mode_level)) // RULE6
        else $error("mode bit read wrong");
    pin_bit_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd && hit(paddr, `EIP_STATUS_CONTROL_OFS)
        |=> prdata[`EIP_PIN_BIT] == $past(state.pin_level)) // RULE14
        else $error("pin bit read wrong");
    stop_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
        stop_wake_seq |=> state.power == EIP_RUN) // RULE16
        else $error("stop mode not left on request");
    wait_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
        wait_wake_seq |=> state.power == EIP_RUN) // RULE15
        else $error("wait mode not left on request");
endmodule // eip_unit
`default_nettype wire
